// *** bcl_loader.v ***
// boot clock loader: strap decode, pll fields, image loader with crc check
// Operation
// - strap pins pick startup divider F; OD is 1, R is 0
// - tile clock is oscillator times (F+1)/2 over (R+1) and (OD+1)
// - software may rewrite OD, F and R at run time via a register
// - during chip reset the block stays reset and pulls GPIOs down
// - booting starts 15 to 150 microseconds after reset release
// - security bit 5 picks OTP source, otherwise the QSPI flash
// - image is size word, size times four bytes, then check word
// - check word equal to the magic value skips the crc check
// - size and check words arrive least significant byte first
// - program goes to RAM from address zero and starts there
// - crc covers the size word and program bytes only
// - crc uses reflected polynomial, all-ones preset, inverted result
`timescale 1ns/100ps
`default_nettype none
`include "bcl_defs.vh"

module bcl_loader (
	input wire aclk,
	input wire aresetn,
	input wire [7:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output reg s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output reg s_axi_wready,
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	input wire [7:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output reg s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	input wire boot_select_low,
	input wire boot_select_high,
	input wire [31:0] security_reg,
	output reg gpio_pulldown_en,
	output reg [5:0] pll_r,
	output reg [11:0] pll_f,
	output reg [2:0] pll_output_divider,
	output reg otp_fetch_req,
	output reg flash_fetch_req,
	input wire [7:0] boot_byte,
	input wire boot_byte_valid,
	output reg boot_byte_ready,
	output reg ram_we,
	output reg [17:0] ram_addr,
	output reg [7:0] ram_wdata,
	output reg core_start,
	output reg [17:0] core_start_addr,
	output reg boot_fail
);

	localparam ST_STRAP = 3'd0, ST_DELAY = 3'd1, ST_SIZE = 3'd2, ST_PROG = 3'd3;
	localparam ST_CHECK = 3'd4, ST_RUN = 3'd5, ST_FAIL = 3'd6;
	localparam [10:0] DELAY_LAST = `BCL_BOOT_DELAY_CYC - 1;

	reg [2:0] state, next_state;
	reg [10:0] delay_cnt;
	reg [1:0] byte_idx, straps;
	reg [31:0] shift_word, words_left, img_words, crc;
	reg [31:0] osc_khz, tile_khz, w_data;
	reg boot_src_otp, aw_held, w_held;
	reg [7:0] aw_addr;
	reg [3:0] w_strb;
	reg [5:0] div_cnt;
	reg [44:0] div_rem, div_quo;
	reg [10:0] div_den;
	wire take, quo_bit;
	wire [31:0] word_in, pll_word, pll_merged, osc_merged;
	wire [44:0] div_trial;
	wire [12:0] f_plus;
	wire [10:0] den_now;

	// one reflected crc byte step, bit 0 first
	function [31:0] crc_byte;
		input [31:0] c;
		input [7:0] d;
		integer i;
		reg [31:0] t;
		begin
			t = c ^ {24'h000000, d};
			for (i = 0; i < 8; i = i + 1) begin
				t = t[0] ? ((t >> 1) ^ `BCL_CRC_POLY) : (t >> 1);
			end
			crc_byte = t;
		end
	endfunction

	// byte-lane merge of a bus write; unstrobed lanes keep their value
	genvar g;
	generate
		for (g = 0; g < 4; g = g + 1) begin : lane
			assign pll_merged[8*g +: 8] =
				w_strb[g] ? w_data[8*g +: 8] : pll_word[8*g +: 8];
			assign osc_merged[8*g +: 8] =
				w_strb[g] ? w_data[8*g +: 8] : osc_khz[8*g +: 8];
		end
	endgenerate

	assign take = boot_byte_valid & boot_byte_ready;
	// assemble a word least significant byte first
	assign word_in = {boot_byte, shift_word[31:8]};
	assign pll_word = {5'h00, pll_output_divider, 4'h0, pll_f, 2'h0, pll_r};

	// loader sequencing
	always @* begin
		next_state = state;
		case (state)
			ST_STRAP: begin
				next_state = ST_DELAY;
			end
			ST_DELAY: begin
				if (delay_cnt == DELAY_LAST) begin
					next_state = ST_SIZE;
				end
			end
			ST_SIZE: begin
				if (take && byte_idx == 2'h3) begin
					next_state = (word_in == 32'h00000000) ? ST_CHECK : ST_PROG;
				end
			end
			ST_PROG: begin
				if (take && byte_idx == 2'h3 && words_left == 32'h00000001) begin
					next_state = ST_CHECK;
				end
			end
			ST_CHECK: begin
				if (take && byte_idx == 2'h3) begin
					if (word_in == `BCL_NO_CRC_MAGIC) begin
						next_state = ST_RUN;
					end else if (word_in == ~crc) begin
						next_state = ST_RUN;
					end else begin
						next_state = ST_FAIL;
					end
				end
			end
			ST_RUN, ST_FAIL: begin
				next_state = state;
			end
			default: begin
				next_state = ST_STRAP;
			end
		endcase
	end

	// image intake, crc and ram writes
	always @(posedge aclk) begin
		if (!aresetn) begin
			state <= ST_STRAP;
			delay_cnt <= 11'h000;
			byte_idx <= 2'h0;
			shift_word <= 32'h00000000;
			words_left <= 32'h00000000;
			img_words <= 32'h00000000;
			crc <= `BCL_CRC_PRESET;
			straps <= 2'h0;
			boot_src_otp <= 1'b0;
			gpio_pulldown_en <= 1'b1;
			otp_fetch_req <= 1'b0;
			flash_fetch_req <= 1'b0;
			boot_byte_ready <= 1'b0;
			ram_we <= 1'b0;
			ram_addr <= 18'h00000;
			ram_wdata <= 8'h00;
			core_start <= 1'b0;
			core_start_addr <= 18'h00000;
			boot_fail <= 1'b0;
		end else begin
			state <= next_state;
			ram_we <= 1'b0;
			core_start <= 1'b0;
			boot_byte_ready <= (next_state == ST_SIZE) ||
				(next_state == ST_PROG) || (next_state == ST_CHECK);
			if (state == ST_STRAP) begin
				// caught one edge after release; pins held steady from here
				straps <= {boot_select_high, boot_select_low};
				boot_src_otp <= security_reg[`BCL_SEC_BOOT_BIT];
			end
			if (state == ST_DELAY) begin
				delay_cnt <= delay_cnt + 11'h001;
			end
			if (next_state == ST_SIZE && state == ST_DELAY) begin
				gpio_pulldown_en <= 1'b0;
				otp_fetch_req <= boot_src_otp;
				flash_fetch_req <= ~boot_src_otp;
			end
			if (take) begin
				shift_word <= word_in;
				byte_idx <= byte_idx + 2'h1;
				if (state != ST_CHECK) begin
					crc <= crc_byte(crc, boot_byte);
				end
				if (state == ST_SIZE && byte_idx == 2'h3) begin
					words_left <= word_in;
					img_words <= word_in;
				end
				if (state == ST_PROG) begin
					ram_we <= 1'b1;
					ram_wdata <= boot_byte;
					if (byte_idx == 2'h3) begin
						words_left <= words_left - 32'h00000001;
					end
				end
			end
			// address steps after each write; first byte lands at zero
			if (ram_we) begin
				ram_addr <= ram_addr + 18'h00001;
			end
			if (state == ST_CHECK && next_state != ST_CHECK) begin
				otp_fetch_req <= 1'b0;
				flash_fetch_req <= 1'b0;
				core_start <= (next_state == ST_RUN);
				core_start_addr <= 18'h00000;
				boot_fail <= (next_state == ST_FAIL);
			end
		end
	end

	// pll fields: strap table at boot, software override after
	always @(posedge aclk) begin
		if (!aresetn) begin
			pll_f <= `BCL_F_SEL00;
			pll_r <= `BCL_R_BOOT;
			pll_output_divider <= `BCL_OD_BOOT;
			osc_khz <= `BCL_OSC_KHZ_RST;
		end else if (state == ST_STRAP) begin
			pll_r <= `BCL_R_BOOT;
			pll_output_divider <= `BCL_OD_BOOT;
			case ({boot_select_high, boot_select_low})
				2'b00: pll_f <= `BCL_F_SEL00;
				2'b11: pll_f <= `BCL_F_SEL11;
				2'b10: pll_f <= `BCL_F_SEL10;
				2'b01: pll_f <= `BCL_F_SEL01;
				default: pll_f <= `BCL_F_SEL00;
			endcase
		end else if (aw_held && w_held && !s_axi_bvalid) begin
			// no range check here: legal values are software's duty
			if (aw_addr == `BCL_REG_PLL) begin
				pll_r <= pll_merged[`BCL_PLL_R_LSB +: 6];
				pll_f <= pll_merged[`BCL_PLL_F_LSB +: 12];
				pll_output_divider <= pll_merged[`BCL_PLL_OD_LSB +: 3];
			end
			if (aw_addr == `BCL_REG_OSC_KHZ) begin
				osc_khz <= osc_merged;
			end
		end
	end

	// tile clock monitor: osc*(F+1) / (2*(R+1)*(OD+1)), 46 cycles a pass
	assign f_plus = {1'b0, pll_f} + 13'h0001;
	// widen before adding one, so r of 63 does not wrap to a zero divisor
	assign den_now = (({5'h00, pll_r} + 11'h001) << 1) *
		({8'h00, pll_output_divider} + 11'h001);
	assign div_trial = {div_rem[43:0], div_quo[44]};
	assign quo_bit = div_trial >= {34'h0, div_den};
	always @(posedge aclk) begin
		if (!aresetn) begin
			div_cnt <= 6'h00;
			div_rem <= 45'h0;
			div_quo <= 45'h0;
			div_den <= 11'h002;
			tile_khz <= 32'h00000000;
		end else if (div_cnt == 6'h00) begin
			div_rem <= 45'h0;
			div_quo <= {13'h0, osc_khz} * {32'h0, f_plus};
			div_den <= den_now;
			div_cnt <= 6'h01;
		end else begin
			if (quo_bit) begin
				div_rem <= div_trial - {34'h0, div_den};
				div_quo <= {div_quo[43:0], 1'b1};
			end else begin
				div_rem <= div_trial;
				div_quo <= {div_quo[43:0], 1'b0};
			end
			if (div_cnt == 6'h2D) begin
				// take the last quotient bit too, not the stale word
				tile_khz <= {div_quo[30:0], quo_bit};
				div_cnt <= 6'h00;
			end else begin
				div_cnt <= div_cnt + 6'h01;
			end
		end
	end

	// bus write side: address and data in either order, one at a time
	always @(posedge aclk) begin
		if (!aresetn) begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_addr <= 8'h00;
			w_data <= 32'h00000000;
			w_strb <= 4'h0;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `BCL_RESP_OKAY;
		end else begin
			s_axi_awready <= !aw_held && !(s_axi_awvalid && s_axi_awready);
			s_axi_wready <= !w_held && !(s_axi_wvalid && s_axi_wready);
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held <= 1'b1;
				aw_addr <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held <= 1'b1;
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
			end
			if (aw_held && w_held && !s_axi_bvalid) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= (aw_addr == `BCL_REG_PLL ||
					aw_addr == `BCL_REG_OSC_KHZ) ? `BCL_RESP_OKAY :
					`BCL_RESP_SLVERR;
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
				aw_held <= 1'b0;
				w_held <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready <= 1'b1;
			end
		end
	end

	// bus read side
	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= `BCL_RESP_OKAY;
		end else begin
			s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp <= `BCL_RESP_OKAY;
				case (s_axi_araddr)
					`BCL_REG_STATUS: s_axi_rdata <= {24'h0, boot_fail,
						boot_src_otp, straps, 1'b0, state};
					`BCL_REG_PLL: s_axi_rdata <= pll_word;
					`BCL_REG_OSC_KHZ: s_axi_rdata <= osc_khz;
					`BCL_REG_TILE_KHZ: s_axi_rdata <= tile_khz;
					`BCL_REG_IMG_WORDS: s_axi_rdata <= img_words;
					`BCL_REG_CRC: s_axi_rdata <= ~crc;
					default: begin
						s_axi_rdata <= 32'h00000000;
						s_axi_rresp <= `BCL_RESP_SLVERR;
					end
				endcase
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
				s_axi_arready <= 1'b1;
			end
		end
	end

endmodule // bcl_loader
`default_nettype wire

// *** bcl_defs.vh ***
// constants for the boot clock loader: register map, fields, timing
`ifndef BCL_DEFS_VH
`define BCL_DEFS_VH
// register byte offsets on the control bus
`define BCL_REG_STATUS 8'h00
`define BCL_REG_PLL 8'h04
`define BCL_REG_OSC_KHZ 8'h08
`define BCL_REG_TILE_KHZ 8'h0C
`define BCL_REG_IMG_WORDS 8'h10
`define BCL_REG_CRC 8'h14
// pll configuration field positions
`define BCL_PLL_R_LSB 0
`define BCL_PLL_F_LSB 8
`define BCL_PLL_OD_LSB 24
// startup pll settings per strap code {high,low}
`define BCL_F_SEL00 12'h09F
`define BCL_F_SEL11 12'h03F
`define BCL_F_SEL10 12'h01F
`define BCL_F_SEL01 12'h00F
`define BCL_OD_BOOT 3'h1
`define BCL_R_BOOT 6'h00
// reset value of the oscillator frequency register, in kHz
`define BCL_OSC_KHZ_RST 32'h00006000
// image format
`define BCL_NO_CRC_MAGIC 32'h0D15AB1E
`define BCL_CRC_POLY 32'hEDB88320
`define BCL_CRC_PRESET 32'hFFFFFFFF
`define BCL_SEC_BOOT_BIT 5
// internal reset delay before boot
`define BCL_CLK_MHZ 100
`define BCL_BOOT_DELAY_US 15
`define BCL_BOOT_DELAY_CYC (`BCL_BOOT_DELAY_US * `BCL_CLK_MHZ)
// bus responses
`define BCL_RESP_OKAY 2'h0
`define BCL_RESP_SLVERR 2'h2
`endif

// *** bcl_loader_checker.sv ***
// port checker for the boot clock loader
`timescale 1ns/100ps
`default_nettype none
module bcl_loader_checker (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic boot_select_low,
	input wire logic boot_select_high,
	input wire logic [31:0] security_reg,
	input wire logic gpio_pulldown_en,
	input wire logic [5:0] pll_r,
	input wire logic [11:0] pll_f,
	input wire logic [2:0] pll_output_divider,
	input wire logic otp_fetch_req,
	input wire logic flash_fetch_req,
	input wire logic boot_byte_valid,
	input wire logic boot_byte_ready,
	input wire logic ram_we,
	input wire logic [17:0] ram_addr,
	input wire logic core_start,
	input wire logic [17:0] core_start_addr,
	input wire logic boot_fail
);
	logic [13:0] cyc;
	wire fetch = otp_fetch_req | flash_fetch_req;
	wire take = boot_byte_valid & boot_byte_ready;
	wire [11:0] f_exp = boot_select_high ?
		(boot_select_low ? 12'h03F : 12'h01F) :
		(boot_select_low ? 12'h00F : 12'h09F);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// cycles since reset exit, saturating so late starts still fail
	always @(posedge aclk) begin
		if (!aresetn)
			cyc <= 14'h0000;
		else if (cyc != 14'h3FFF)
			cyc <= cyc + 14'h0001;
	end
	rst_pull_a: assert property (
		$rose(aresetn) |-> gpio_pulldown_en && pll_r == 6'h00)
		else $error("pulldown or r wrong at reset exit");
	strap_pll_a: assert property (
		$rose(aresetn) |=> pll_f == f_exp && pll_output_divider == 3'h1)
		else $error("startup divider does not follow straps");
	boot_delay_a: assert property (
		$rose(fetch) |-> cyc >= 14'h05DC && cyc <= 14'h3A98)
		else $error("boot start outside delay window");
	boot_src_a: assert property (
		fetch |-> otp_fetch_req == security_reg[5] && !(otp_fetch_req && flash_fetch_req))
		else $error("wrong boot source");
	ready_gate_a: assert property (
		boot_byte_ready |-> fetch)
		else $error("byte ready outside fetch");
	ram_cause_a: assert property (
		ram_we |-> $past(take))
		else $error("ram write without taken byte");
	ram_step_a: assert property (
		ram_we |=> ram_addr == $past(ram_addr) + 18'h00001)
		else $error("ram address did not step");
	start_once_a: assert property (
		core_start |-> core_start_addr == 18'h00000 && !boot_fail ##1 !core_start)
		else $error("bad start pulse");
	fail_hold_a: assert property (
		boot_fail |=> boot_fail && !core_start)
		else $error("failure flag not sticky");
endmodule // bcl_loader_checker
bind bcl_loader bcl_loader_checker chk (.*);
`default_nettype wire

// *** bcl_flash_model.sv ***
// boot image source model: streams image bytes while a fetch is requested
`timescale 1ns/100ps
`default_nettype none
module bcl_flash_model (
	input wire logic aclk,
	input wire logic fetch,
	input wire logic boot_byte_ready,
	output var logic [7:0] boot_byte,
	output var logic boot_byte_valid
);
	logic [7:0] img [0:63];
	int len = 0;
	int idx = 0;
	int n;
	bit slow = 0;
	bit tog = 0;
	initial begin
		boot_byte = 8'h00;
		boot_byte_valid = 1'b0;
	end
	// a pending byte is held until taken; idle data toggles, never stale
	always @(posedge aclk) begin
		n = fetch ? idx + int'(boot_byte_valid && boot_byte_ready) : 0;
		idx <= n;
		tog <= ~tog;
		if (!(fetch && boot_byte_valid && !boot_byte_ready)) begin
			boot_byte_valid <= fetch && n < len && !(slow && tog);
			boot_byte <= (fetch && n < len) ? img[n] : ~boot_byte;
		end
	end
endmodule // bcl_flash_model
`default_nettype wire

// *** boot_clock_loader_bench.sv ***
// testbench of the boot clock loader
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin \
	compares++; \
	if ((g) !== (e)) begin \
		fails++; \
		$display("[FAIL] %s exp %h got %h", nm, e, g); \
	end \
end
module boot_clock_loader_bench;
	logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_rready, s_axi_awready, s_axi_wready;
	logic s_axi_bvalid, s_axi_arready, s_axi_rvalid, boot_select_low;
	logic boot_select_high, gpio_pulldown_en, otp_fetch_req;
	logic flash_fetch_req, boot_byte_valid, boot_byte_ready, ram_we;
	logic core_start, boot_fail;
	logic [7:0] s_axi_awaddr, s_axi_araddr, boot_byte, ram_wdata;
	logic [31:0] s_axi_wdata, s_axi_rdata, security_reg, rd;
	logic [1:0] s_axi_bresp, s_axi_rresp, rs;
	logic [3:0] s_axi_wstrb;
	logic [5:0] pll_r;
	logic [11:0] pll_f;
	logic [2:0] pll_output_divider;
	logic [17:0] ram_addr, core_start_addr;
	int fails = 0;
	int compares = 0;
	int wcnt = 0;
	bcl_loader uut (.*);
	bcl_flash_model src (.aclk, .fetch(otp_fetch_req | flash_fetch_req),
		.boot_byte_ready, .boot_byte, .boot_byte_valid);
	initial begin
		aclk = 0;
		forever #5 aclk = ~aclk;
	end
	task end_sim;
		if (fails == 0 && compares > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	function automatic logic [31:0] crc8(input logic [31:0] c,
		input logic [7:0] d);
		c = c ^ {24'h000000, d};
		for (int i = 0; i < 8; i++) c = c[0] ? (c >> 1) ^ 32'hEDB88320 : c >> 1;
		return c;
	endfunction
	// kind 0 real check word, 1 waiver value, 2 corrupted check word
	task automatic mk(input int s, input int kind);
		logic [31:0] c;
		c = 32'hFFFFFFFF;
		src.len = 8 + 4 * s;
		for (int i = 0; i < src.len - 4; i++) begin
			src.img[i] = i < 4 ? 8'(s >> (8 * i)) : 8'(i * 29 + 3);
			c = crc8(c, src.img[i]);
		end
		c = kind == 1 ? 32'h0D15AB1E : ~c ^ 32'(kind == 2);
		for (int i = 0; i < 4; i++) src.img[src.len - 4 + i] = c[8 * i +: 8];
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (!s_axi_bvalid);
		rs = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask
	task automatic rd_reg(input logic [7:0] a);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (!s_axi_rvalid);
		rd = s_axi_rdata;
		rs = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask
	// every program byte lands in order from address zero
	always @(posedge aclk) begin
		if (ram_we) begin
			`CHK("ram_addr", 18'(wcnt), ram_addr)
			`CHK("ram_wdata", src.img[4 + wcnt], ram_wdata)
			wcnt++;
		end
	end
	task automatic boot(input logic [1:0] st, input bit sec, input int s,
		input int kind);
		int n;
		logic [11:0] f;
		f = st == 2'b00 ? 12'h09F : st == 2'b11 ? 12'h03F :
			st == 2'b10 ? 12'h01F : 12'h00F;
		mk(s, kind);
		src.slow = sec;
		wcnt = 0;
		@(posedge aclk);
		aresetn <= 1'b0;
		{boot_select_high, boot_select_low} <= st;
		security_reg <= {26'h0000000, sec, 5'h00};
		repeat (5) @(posedge aclk);
		`CHK("pulldown", 1'b1, gpio_pulldown_en)
		aresetn <= 1'b1;
		n = 0;
		while (!(core_start || boot_fail) && n < 20000) begin
			@(posedge aclk);
			n++;
			if (n == 3) `CHK("pll", {3'h1, f, 6'h00}, {pll_output_divider, pll_f, pll_r})
			if (n == 1400) `CHK("early", 2'h0, {otp_fetch_req, flash_fetch_req})
			if (n == 1506) `CHK("source", {sec, ~sec}, {otp_fetch_req, flash_fetch_req})
		end
		`CHK("start", kind != 2, core_start)
		`CHK("fail", kind == 2, boot_fail)
		`CHK("entry", 18'h00000, core_start_addr)
		`CHK("words", s * 4, wcnt)
		`CHK("pulldown_off", 1'b0, gpio_pulldown_en)
		repeat (100) @(posedge aclk);
		rd_reg(8'h0C);
		`CHK("tile", 32'(24576 * (f + 1) / 4), rd)
		rd_reg(8'h00);
		`CHK("status", kind == 2, rd[7])
	endtask
	initial begin
		aresetn = 1'b0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
		{s_axi_arvalid, s_axi_rready} = 2'h0;
		{boot_select_high, boot_select_low} = 2'h0;
		s_axi_awaddr = 8'h00;
		s_axi_araddr = 8'h00;
		s_axi_wdata = 32'h00000000;
		s_axi_wstrb = 4'hF;
		security_reg = 32'h00000000;
		boot(2'b00, 1'b0, 2, 0);
		boot(2'b01, 1'b1, 1, 1);
		boot(2'b10, 1'b0, 1, 2);
		boot(2'b11, 1'b1, 0, 0);
		// run-time divider change: r 1, f 0x3F, divider 3
		wr(8'h04, 32'h03003F01);
		`CHK("pll_wresp", 2'h0, rs)
		repeat (2) @(posedge aclk);
		`CHK("pll_w", {3'h3, 12'h03F, 6'h01}, {pll_output_divider, pll_f, pll_r})
		rd_reg(8'h04);
		`CHK("pll_rd", 32'h03003F01, rd)
		repeat (100) @(posedge aclk);
		rd_reg(8'h0C);
		`CHK("tile_w", 32'h00018000, rd)
		rd_reg(8'h08);
		`CHK("osc", 32'h00006000, rd)
		wr(8'h20, 32'h00000001);
		`CHK("bad_w", 2'h2, rs)
		rd_reg(8'h20);
		`CHK("bad_r", {2'h2, 32'h00000000}, {rs, rd})
		end_sim;
	end
	// hang guard, well beyond four boots and the register traffic
	initial begin
		#500000;
		fails++;
		end_sim;
	end
endmodule // boot_clock_loader_bench
`default_nettype wire
